// ### verilog/gate_fault_pkg.sv
// Purpose: Shared constants for the gate driver fault manager
// Assumes: 125 MHz system clock, AXI4-Lite with 32-bit data
// Notes:   Every offset, field position, count and control reset value lives here

package gate_fault_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS      = 8;     // 125 MHz system clock
  localparam int unsigned SHORT_PULSE_NS     = 100;   // Below this on-time a pulse counts as short
  localparam int unsigned SHORT_PULSE_CYCLES = (SHORT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ON_COUNT_W         = 8;     // Saturating on-time counter width

  // ****************************************************************
  // Pin vector layout (after synchronisation)
  // ****************************************************************
  localparam int unsigned PIN_PWM   = 0;
  localparam int unsigned PIN_SRE   = 1;
  localparam int unsigned PIN_HS_OC = 2;
  localparam int unsigned PIN_OUT_OC = 3;
  localparam int unsigned PIN_GATE_SUPPLY_UNDERVOLTAGE_LOCKOUT  = 4;
  localparam int unsigned PIN_THERM = 5;
  localparam int unsigned PIN_W     = 6;

  // ****************************************************************
  // Fault source indices
  // ****************************************************************
  localparam int unsigned FLT_HS  = 0;
  localparam int unsigned FLT_OUT = 1;
  localparam int unsigned FLT_UV  = 2;
  localparam int unsigned FLT_TH  = 3;
  localparam int unsigned NUM_FAULTS = 4;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned AXI_ADDR_W = 4;
  localparam int unsigned AXI_DATA_W = 32;
  localparam logic [3:0] OFFSET_CONTROL = 4'h0;
  localparam logic [3:0] OFFSET_STATUS  = 4'h4;
  localparam logic [3:0] OFFSET_EVENTS  = 4'h8;

  // Control fields
  localparam int unsigned CTRL_STREAK_LSB = 0;
  localparam int unsigned STREAK_W        = 4;
  localparam int unsigned CTRL_BLANK_LSB  = 8;
  localparam int unsigned BLANK_W         = 8;
  localparam logic [3:0] STREAK_RESET     = 4'h2;
  localparam logic [7:0] BLANK_RESET      = 8'h00;

  // Status fields
  localparam int unsigned ST_FLAG     = 0;
  localparam int unsigned ST_FAULT_LSB = 1;
  localparam int unsigned ST_HIGH_SIDE_GATE_DRIVE  = 5;
  localparam int unsigned ST_LOW_SIDE_GATE_DRIVE  = 6;
  localparam int unsigned ST_OC_LATCH = 7;

  // Event field sits at bit 0, one bit per fault source
  localparam int unsigned EV_LSB = 0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gate_fault_pkg

// ### verilog/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to clk_sys
// Notes:   Output moves only when stages two and three agree, or to stage three under reset

`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinRaw,
  output var  logic [WIDTH-1:0] pinClean
);
  import gate_fault_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] stage1;   // Metastable stage, read by stage2 only
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] clean;    // Filtered level
  } sync_t;

  sync_t s;
  sync_t next_s;

  // Per-bit chain; out of reset a glitch of one cycle never reaches clean
  always_comb begin
    next_s        = s;
    next_s.stage1 = pinRaw;
    next_s.stage2 = s.stage1;
    next_s.stage3 = s.stage2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s.stage2[i] == s.stage3[i]) begin
        next_s.clean[i] = s.stage3[i];
      end
    end
  end

  // Register the state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // Chain keeps sampling under reset, so the pins are already valid at
      // release; a cleared filter would show a false healthy supply
      s       <= next_s;
      s.clean <= s.stage3;
    end else begin
      s <= next_s;
    end
  end

  assign pinClean = s.clean;

endmodule : pin_sync

`default_nettype wire

// ### verilog/blanking_timer.sv
// Purpose: Blanking window after each switch node rising edge
// Assumes: start is a one-cycle pulse on the clock domain
// Notes:   A length of zero gives no window at all

`timescale 1ns/1ns
`default_nettype none

module blanking_timer #(
  parameter int unsigned LEN_W = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             start,
  input  wire logic [LEN_W-1:0] length,
  output var  logic             busy
);
  import gate_fault_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [LEN_W-1:0] count;   // Cycles of window left
    logic             busy;    // Window is open
  } blank_t;

  blank_t s;
  blank_t next_s;

  // Restart on every edge; count down to zero
  always_comb begin
    next_s = s;
    if (start) begin
      next_s.count = length;
      next_s.busy  = (length != '0);
    end else if (s.count > LEN_W'(1)) begin
      next_s.count = s.count - LEN_W'(1);
    end else begin
      next_s.count = '0;
      next_s.busy  = 1'b0;
    end
  end

  // Register the state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;

endmodule : blanking_timer

`default_nettype wire

// ### verilog/gate_fault_manager.sv
// Purpose: Fault supervision for a synchronous-buck gate driver
// Assumes: Fault sources arrive as digital levels from pins
// Notes:   Gates and flag respond a few cycles after the pins move,
//          because every pin passes a three-stage synchroniser

`timescale 1ns/1ns
`default_nettype none

module gate_fault_manager (
  input  wire logic                                  clk_sys,
  input  wire logic                                  reset,
  // Driver pins
  input  wire logic                                  pwm,
  input  wire logic                                  syncRectifierEnable,
  input  wire logic                                  highSideOvercurrent,
  input  wire logic                                  outputOvercurrent,
  input  wire logic                                  gateSupplyUndervoltageLockout,
  input  wire logic                                  thermalShutdown,
  output var  logic                                  highSideGateDrive,
  output var  logic                                  lowSideGateDrive,
  output var  logic                                  faultFlagOut,
  // AXI4-Lite slave
  input  wire logic [gate_fault_pkg::AXI_ADDR_W-1:0] awaddr,
  input  wire logic                                  awvalid,
  output var  logic                                  awready,
  input  wire logic [gate_fault_pkg::AXI_DATA_W-1:0] wdata,
  input  wire logic [3:0]                            wstrb,
  input  wire logic                                  wvalid,
  output var  logic                                  wready,
  output var  logic [1:0]                            bresp,
  output var  logic                                  bvalid,
  input  wire logic                                  bready,
  input  wire logic [gate_fault_pkg::AXI_ADDR_W-1:0] araddr,
  input  wire logic                                  arvalid,
  output var  logic                                  arready,
  output var  logic [gate_fault_pkg::AXI_DATA_W-1:0] rdata,
  output var  logic [1:0]                            rresp,
  output var  logic                                  rvalid,
  input  wire logic                                  rready
);
  import gate_fault_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                  pwmPrev;       // PWM one cycle ago, for edges
    logic                  pulseClean;    // No fault seen in this on-time
    logic [ON_COUNT_W-1:0] onCount;       // Saturating on-time length
    logic [STREAK_W-1:0]   cleanStreak;   // Consecutive clean short pulses
    logic                  ocLatched;     // Over-current flag memory
    logic                  hsTruncated;   // High-side pulse cut short
    logic                  outOcHeld;     // Output over-current, held in blanking
    logic                  hsGate;        // High-side gate drive
    logic                  lsGate;        // Low-side gate drive
    logic                  flag;          // Fault flag pin
    logic [NUM_FAULTS-1:0] faultPrev;     // Qualified faults last cycle
    logic [NUM_FAULTS-1:0] events;        // Sticky fault onset bits
    logic [STREAK_W-1:0]   streakNeeded;  // Clean short pulses to clear
    logic [BLANK_W-1:0]    blankCycles;   // Blanking length in cycles
    logic                  awHeld;        // Write address taken
    logic [AXI_ADDR_W-1:0] awAddr;
    logic                  wHeld;         // Write data taken
    logic [AXI_DATA_W-1:0] wData;
    logic [3:0]            wStrb;
    logic                  bValid;
    logic [1:0]            bResp;
    logic                  rValid;
    logic [AXI_DATA_W-1:0] rData;
    logic [1:0]            rResp;
  } state_t;

  state_t s;
  state_t next_s;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [PIN_W-1:0] pinRaw;    // Pins gathered into one vector
  logic [PIN_W-1:0] pinClean;  // Filtered levels

  // Fault levels are taken as clean digital indications
  assign pinRaw = {thermalShutdown, gateSupplyUndervoltageLockout,
                   outputOvercurrent, highSideOvercurrent,
                   syncRectifierEnable, pwm};

  pin_sync #(
    .WIDTH    (PIN_W)
  ) u_pin_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .pinRaw   (pinRaw),
    .pinClean (pinClean)
  );

  // ****************************************************************
  // Blanking window
  // ****************************************************************
  logic hsWant;       // High-side gate will be on next cycle
  logic hsRise;       // Switch node about to rise
  logic blankBusy;    // Comparators held off

  // The switch node rises with the high-side gate, so that edge opens it
  assign hsRise = hsWant & ~s.hsGate;

  blanking_timer #(
    .LEN_W   (BLANK_W)
  ) u_blanking_timer (
    .clk_sys (clk_sys),
    .reset   (reset),
    .start   (hsRise),
    .length  (s.blankCycles),
    .busy    (blankBusy)
  );

  // ****************************************************************
  // Fault qualification
  // ****************************************************************
  logic                  pwmIn;       // Synchronised PWM
  logic                  sreIn;       // Synchronised rectifier enable
  logic                  hsOcQual;    // High-side over-current after blanking
  logic                  outOcQual;   // Output over-current after hold
  logic                  supplyTrip;  // Undervoltage or thermal shutdown
  logic                  anyOc;       // Either over-current
  logic                  anyFault;    // Any of the four sources
  logic [NUM_FAULTS-1:0] faultVec;    // Qualified sources, by index

  assign pwmIn      = pinClean[PIN_PWM];
  assign sreIn      = pinClean[PIN_SRE];
  assign hsOcQual   = pinClean[PIN_HS_OC] & ~blankBusy;
  assign outOcQual  = blankBusy ? s.outOcHeld : pinClean[PIN_OUT_OC];
  assign supplyTrip = pinClean[PIN_GATE_SUPPLY_UNDERVOLTAGE_LOCKOUT] | pinClean[PIN_THERM];
  assign anyOc      = hsOcQual | outOcQual;
  assign anyFault   = anyOc | supplyTrip;

  assign faultVec[FLT_HS]  = hsOcQual;
  assign faultVec[FLT_OUT] = outOcQual;
  assign faultVec[FLT_UV]  = pinClean[PIN_GATE_SUPPLY_UNDERVOLTAGE_LOCKOUT];
  assign faultVec[FLT_TH]  = pinClean[PIN_THERM];

  // Supply and thermal faults veto any high-side pulse, truncated or not
  assign hsWant = pwmIn & ~s.hsTruncated & ~anyOc & ~supplyTrip;

  // ****************************************************************
  // Bus decode helpers
  // ****************************************************************
  logic [AXI_ADDR_W-1:0] wrAddr;    // Aligned write address
  logic [AXI_ADDR_W-1:0] rdAddr;    // Aligned read address
  logic                  wrFire;    // Both halves of a write present
  logic [AXI_DATA_W-1:0] statusWord;
  logic [AXI_DATA_W-1:0] controlWord;
  logic [NUM_FAULTS-1:0] evClear;   // Write-one-to-clear mask

  assign wrAddr = {s.awAddr[AXI_ADDR_W-1:2], 2'h0};
  assign rdAddr = {araddr[AXI_ADDR_W-1:2], 2'h0};
  assign wrFire = s.awHeld & s.wHeld & ~s.bValid;

  // Address and data each stall once their own half is stored, and while a write response waits
  assign awready = ~s.awHeld & ~s.bValid;
  assign wready  = ~s.wHeld & ~s.bValid;
  assign arready = ~s.rValid;

  always_comb begin
    statusWord                                      = '0;
    statusWord[ST_FLAG]                             = s.flag;
    statusWord[ST_FAULT_LSB +: NUM_FAULTS]          = faultVec;
    statusWord[ST_HIGH_SIDE_GATE_DRIVE]                          = s.hsGate;
    statusWord[ST_LOW_SIDE_GATE_DRIVE]                          = s.lsGate;
    statusWord[ST_OC_LATCH]                         = s.ocLatched;
    controlWord                                     = '0;
    controlWord[CTRL_STREAK_LSB +: STREAK_W]        = s.streakNeeded;
    controlWord[CTRL_BLANK_LSB +: BLANK_W]          = s.blankCycles;
  end

  // Event clear only when the low byte lane is written
  assign evClear = (wrFire && wrAddr == OFFSET_EVENTS && s.wStrb[0])
                   ? s.wData[EV_LSB +: NUM_FAULTS] : '0;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic pwmRise;      // PWM went high
  logic pwmFall;      // PWM went low
  logic shortPulse;   // Ending pulse was under the short limit

  assign pwmRise    = pwmIn & ~s.pwmPrev;
  assign pwmFall    = ~pwmIn & s.pwmPrev;
  assign shortPulse = (s.onCount < ON_COUNT_W'(SHORT_PULSE_CYCLES));

  always_comb begin
    next_s         = s;
    next_s.pwmPrev = pwmIn;

    // Output current level follows only outside the blanking window
    if (!blankBusy) begin
      next_s.outOcHeld = pinClean[PIN_OUT_OC];
    end

    // On-time tracking: any fault spoils the pulse
    if (pwmRise) begin
      next_s.pulseClean = ~anyFault;
      next_s.onCount    = ON_COUNT_W'(1);
    end else if (pwmIn) begin
      if (anyFault) begin
        next_s.pulseClean = 1'b0;
      end
      if (s.onCount != '1) begin
        next_s.onCount = s.onCount + ON_COUNT_W'(1);
      end
    end

    // Over-current flag release at the falling edge of a clean pulse
    if (pwmFall && s.ocLatched) begin
      if (!s.pulseClean || anyFault) begin
        next_s.cleanStreak = '0;
      end else if (!shortPulse) begin
        next_s.ocLatched   = 1'b0;
        next_s.cleanStreak = '0;
      end else if (s.cleanStreak + STREAK_W'(1) >= s.streakNeeded) begin
        // Short pulses may not show a fault, so several are demanded
        next_s.ocLatched   = 1'b0;
        next_s.cleanStreak = '0;
      end else begin
        next_s.cleanStreak = s.cleanStreak + STREAK_W'(1);
      end
    end

    // Setting wins over a release in the same cycle
    if (anyOc) begin
      next_s.ocLatched   = 1'b1;
      next_s.cleanStreak = '0;
    end

    // Re-arm the high side at each rising edge unless blocked
    if (pwmRise && !outOcQual && !supplyTrip) begin
      next_s.hsTruncated = 1'b0;
    end
    if (anyOc) begin
      next_s.hsTruncated = 1'b1;
    end

    // High-side gate: output over-current keeps it off, no per-cycle reset
    next_s.hsGate = hsWant;

    // Low-side gate: off under every fault, and never with the high side
    next_s.lsGate = ~pwmIn & sreIn & ~s.hsGate & ~anyOc & ~supplyTrip;

    // Flag: latched over-current or a live supply or thermal fault;
    // supply and thermal terms drop out on their own once the pin clears
    next_s.flag = next_s.ocLatched | supplyTrip;

    // Sticky onset bits; a new onset beats a clear in the same cycle
    next_s.faultPrev = faultVec;
    next_s.events    = (s.events & ~evClear) | (faultVec & ~s.faultPrev);

    // Write channel capture
    if (awvalid && awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end

    // Write execution once both halves are in
    if (wrFire) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = RESP_OKAY;
      case (wrAddr)
        OFFSET_CONTROL: begin
          if (s.wStrb[0]) begin
            next_s.streakNeeded = s.wData[CTRL_STREAK_LSB +: STREAK_W];
          end
          if (s.wStrb[1]) begin
            next_s.blankCycles = s.wData[CTRL_BLANK_LSB +: BLANK_W];
          end
        end
        OFFSET_STATUS: begin
          // Read-only; write accepted and dropped
        end
        OFFSET_EVENTS: begin
          // Clearing handled above through evClear
        end
        default: begin
          next_s.bResp = RESP_SLVERR;
        end
      endcase
    end else if (s.bValid && bready) begin
      next_s.bValid = 1'b0;
    end

    // Read channel: answer one cycle after the address is taken
    if (arvalid && arready) begin
      next_s.rValid = 1'b1;
      next_s.rResp  = RESP_OKAY;
      case (rdAddr)
        OFFSET_CONTROL: begin
          next_s.rData = controlWord;
        end
        OFFSET_STATUS: begin
          next_s.rData = statusWord;
        end
        OFFSET_EVENTS: begin
          next_s.rData = AXI_DATA_W'(s.events);
        end
        default: begin
          next_s.rData = '0;
          next_s.rResp = RESP_SLVERR;
        end
      endcase
    end else if (s.rValid && rready) begin
      next_s.rValid = 1'b0;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Flag starts high: gate supply is unproven until pins are seen
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s              <= '0;
      s.flag         <= 1'b1;
      s.streakNeeded <= STREAK_RESET;
      s.blankCycles  <= BLANK_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign highSideGateDrive = s.hsGate;
  assign lowSideGateDrive  = s.lsGate;
  assign faultFlagOut      = s.flag;
  assign bvalid            = s.bValid;
  assign bresp             = s.bResp;
  assign rvalid            = s.rValid;
  assign rdata             = s.rData;
  assign rresp             = s.rResp;

endmodule : gate_fault_manager

`default_nettype wire

// ### verif/gate_fault_manager_props.sv
// Purpose: Port assertions for the fault manager
// Assumes: About five cycles from pin to output
// Notes:   Windows of six to eight cycles cover that lag
`timescale 1ns/1ns
`default_nettype none
module gate_fault_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pwm,
  input wire logic highSideOvercurrent,
  input wire logic outputOvercurrent,
  input wire logic gateSupplyUndervoltageLockout,
  input wire logic thermalShutdown,
  input wire logic highSideGateDrive,
  input wire logic lowSideGateDrive,
  input wire logic faultFlagOut
);
  // Short aliases keep each property but a_hs_rearm on one line
  wire logic uv   = gateSupplyUndervoltageLockout;
  wire logic hot  = thermalShutdown;
  wire logic off  = !highSideGateDrive && !lowSideGateDrive;
  wire logic anyF = highSideOvercurrent | outputOvercurrent | uv | hot;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_hot_gates_off: assert property (hot[*6] |-> off) else $error("gates on in shutdown");
  a_uv_gates_off: assert property (uv[*6] |-> off) else $error("gates on in lockout");
  a_uv_flag_set: assert property (uv[*6] |-> faultFlagOut) else $error("no flag in lockout");
  a_hot_flag_set: assert property (hot[*6] |-> faultFlagOut) else $error("no flag in shutdown");
  a_out_oc_off: assert property (outputOvercurrent[*6] |-> off) else $error("gates on in fault");
  a_hs_oc_flag: assert property ($rose(highSideOvercurrent) |-> ##[1:8] faultFlagOut) else $error("no flag");
  a_flag_source: assert property ((!anyF)[*8] |-> !$rose(faultFlagOut)) else $error("flag no cause");
  a_hs_rearm: assert property ((!anyF)[*4] ##1 ($rose(pwm) && !anyF) ##1 (pwm && !anyF)[*8]
    |-> highSideGateDrive) else $error("high gate not issued");
  a_uv_flag_boot: assert property (($fell(reset) && uv) |-> faultFlagOut[*4]) else $error("flag dropped at boot");
endmodule : gate_fault_props
bind gate_fault_manager gate_fault_props i_gate_fault_props (.clk_sys, .reset, .pwm, .highSideOvercurrent,
  .outputOvercurrent, .gateSupplyUndervoltageLockout, .thermalShutdown, .highSideGateDrive,
  .lowSideGateDrive, .faultFlagOut);
`default_nettype wire

// ### verif/host_pwm_model.sv
// Purpose: Host controller model driving PWM and rectifier enable
// Assumes: The bench calls pulse right after a clock edge
// Notes:   Rectifier stays off until the flag first shows power good
`timescale 1ns/1ns
`default_nettype none
module host_pwm_model (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic faultFlagOut,
  output var  logic pwm,
  output var  logic syncRectifierEnable
);
  initial begin
    pwm = 1'h0;
    syncRectifierEnable = 1'h0;
  end
  // Conversion starts only after gate drive power is good
  always @(posedge clk_sys) begin
    if (!reset && faultFlagOut === 1'h0) begin
      syncRectifierEnable <= 1'h1;
    end
  end
  // One pulse: on-time then off-time, in clock cycles
  task automatic pulse(input int onLen, input int offLen);
    pwm <= 1'h1;
    repeat (onLen) @(posedge clk_sys);
    pwm <= 1'h0;
    repeat (offLen) @(posedge clk_sys);
  endtask : pulse
endmodule : host_pwm_model
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the fault manager
// Assumes: Pin to output takes about five cycles
// Notes:   Fault pins and bus driven here, PWM by the host model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gate_fault_pkg::*;
  logic clk_sys, reset, hsOc, outOc, uv, hot, pwm, sync_rectifier_enable, hsG, lsG, flag;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int failCount = 0;
  int checked = 0;
  gate_fault_manager i_gate_fault_manager (.clk_sys, .reset, .pwm, .syncRectifierEnable(sync_rectifier_enable),
    .highSideOvercurrent(hsOc), .outputOvercurrent(outOc), .gateSupplyUndervoltageLockout(uv),
    .thermalShutdown(hot), .highSideGateDrive(hsG), .lowSideGateDrive(lsG), .faultFlagOut(flag),
    .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  host_pwm_model i_host_pwm_model (.clk_sys, .reset, .faultFlagOut(flag), .pwm, .syncRectifierEnable(sync_rectifier_enable));
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      failCount++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  // Flag sits behind a synchroniser, so wait a bounded span
  task automatic waitFlag(input logic v, input string m);
    for (int n = 0; n < 12 && flag !== v; n++) cyc(1);
    chk(flag === v, m);
  endtask : waitFlag
  // Bus write: each channel held until its own handshake
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    cyc(1);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 40 && !(aw && w && bvalid === 1'h1); n++) begin
      cyc(1);
      if (awready && !aw) begin
        aw = 1;
        awvalid <= 1'h0;
      end
      if (wready && !w) begin
        w = 1;
        wvalid <= 1'h0;
      end
    end
    chk(aw && w && bvalid === 1'h1, "write not answered");
    rs = bresp;
    bready <= 1'h0;
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    bit ar;
    ar = 0;
    cyc(1);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 40 && !(ar && rvalid === 1'h1); n++) begin
      cyc(1);
      if (arready && !ar) begin
        ar = 1;
        arvalid <= 1'h0;
      end
    end
    chk(ar && rvalid === 1'h1, "read not answered");
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask : rdr
  // Long pulse with the high gate sampled mid on-time
  task automatic pulseChk(input logic g, input string m);
    fork
      i_host_pwm_model.pulse(20, 12);
      begin
        cyc(12);
        chk(hsG === g, m);
      end
    join
  endtask : pulseChk
  task automatic hsTrip;
    hsOc <= 1'h1;
    cyc(3);
    hsOc <= 1'h0;
    waitFlag(1'h1, "no flag on trip");
    chk(lsG === 1'h0, "low gate on in trip");
  endtask : hsTrip
  task automatic tSupply;
    chk({flag, hsG, lsG} === 3'h4, "lockout state");
    uv <= 1'h0;
    waitFlag(1'h0, "flag held after lockout");
    cyc(8);
    chk(lsG === 1'h1, "low gate not returned");
    hot <= 1'h1;
    waitFlag(1'h1, "no shutdown flag");
    chk({hsG, lsG} === 2'h0, "gates on in shutdown");
    hot <= 1'h0;
    waitFlag(1'h0, "flag held after shutdown");
  endtask : tSupply
  task automatic tOc;
    hsTrip;
    cyc(20);
    chk(flag === 1'h1, "flag cleared idle");
    outOc <= 1'h1;
    cyc(6);
    pulseChk(1'h0, "high gate in output fault");
    chk(flag === 1'h1, "cleared by faulty pulse");
    outOc <= 1'h0;
    cyc(8);
    pulseChk(1'h1, "high gate not re-armed");
    chk(flag === 1'h0, "kept after clean pulse");
    hsTrip;
    cyc(8);
    i_host_pwm_model.pulse(5, 12);
    chk(flag === 1'h1, "cleared by one short pulse");
    i_host_pwm_model.pulse(5, 12);
    chk(flag === 1'h0, "kept after short pulses");
  endtask : tOc
  task automatic tRegs;
    rdr(OFFSET_CONTROL);
    chk(rd === {16'h0, BLANK_RESET, 4'h0, STREAK_RESET} && rs === RESP_OKAY, "control reset");
    wr(OFFSET_STATUS, 32'hffff_ffff);
    rdr(OFFSET_STATUS);
    chk(rd[ST_FLAG] === 1'h0 && rs === RESP_OKAY, "status written");
    rdr(OFFSET_EVENTS);
    chk((rd[FLT_HS] & rd[FLT_OUT] & rd[FLT_TH]) === 1'h1, "events missed");
    wr(OFFSET_EVENTS, 32'h0000_000f);
    rdr(OFFSET_EVENTS);
    chk(rd[3:0] === 4'h0, "events kept");
    wr(4'hc, 32'h0);
    chk(rs === RESP_SLVERR, "unmapped write");
    rdr(4'hc);
    chk(rd === 32'h0 && rs === RESP_SLVERR, "unmapped read");
  endtask : tRegs
  task automatic complete_run;
    if (failCount == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // Supply starts below lockout, as at power-up
  initial begin
    {reset, uv, hsOc, outOc, hot} = 5'h18;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = '0;
    cyc(12);
    reset <= 1'h0;
    cyc(8);
    tSupply;
    tOc;
    tRegs;
    complete_run;
  end
  // Run needs about 2 us; twenty times that means a hang
  initial begin
    #40000;
    failCount++;
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
